// file: src/comparator_event_pkg.sv
// Shared constants, register map and carrier types of the comparator event control
package comparator_event_pkg;

  // ----------------------------------------------------------------------
  // Register map (word index; byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned INDEX_W   = 10;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned REG_W     = 8;
  localparam int unsigned SYNC_DEPTH = 2;

  localparam logic [INDEX_W-1:0] CSR_INDEX        = 10'h050;
  localparam logic [INDEX_W-1:0] INSEL_INDEX      = 10'h07d;
  localparam logic [INDEX_W-1:0] DIDR_INDEX       = 10'h07e;
  localparam logic [INDEX_W-1:0] IRQ_STATUS_INDEX = 10'h07f;
  localparam logic [INDEX_W-1:0] IRQ_MASK_INDEX   = 10'h080;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CSR_OFF_BIT    = 7;
  localparam int unsigned CSR_BG_BIT     = 6;
  localparam int unsigned CSR_RESULT_BIT = 5;
  localparam int unsigned CSR_FLAG_BIT   = 4;
  localparam int unsigned CSR_IE_BIT     = 3;
  localparam int unsigned CSR_CAP_BIT    = 2;
  localparam int unsigned CSR_MODE_HI    = 1;
  localparam int unsigned CSR_MODE_LO    = 0;

  localparam int unsigned NEG_SEL_W  = 3;
  localparam int unsigned NEG_PINS   = 6;
  localparam int unsigned PIN_COUNT  = 7;
  localparam int unsigned IRQ_W      = 2;
  localparam int unsigned IRQ_EVENT_BIT  = 0;
  localparam int unsigned IRQ_TOGGLE_BIT = 1;

  localparam logic [NEG_SEL_W-1:0] NEG_SEL_RESET = 3'h0;
  localparam logic [PIN_COUNT-1:0] BUF_OFF_RESET = 7'h00;
  localparam logic [IRQ_W-1:0]     IRQ_RESET     = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TOGGLE   = 2'b00,
    MODE_RESERVED = 2'b01,
    MODE_FALL     = 2'b10,
    MODE_RISE     = 2'b11
  } eventMode_t;

  typedef enum logic {
    WR_COLLECT = 1'b0,
    WR_RESPOND = 1'b1
  } wrState_t;

  typedef struct packed {
    logic       comparatorOff;
    logic       bandgapSelect;
    logic       compareIrqEnable;
    logic       captureRouteEnable;
    eventMode_t eventMode;
  } ctrl_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axiReq_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } axiRsp_t;

endpackage

// file: src/comparator_sync.sv
// Two-stage synchroniser for the asynchronous comparator output
`timescale 1ns/1ps
module comparator_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Signal
  input  wire logic asyncIn,
  output logic      syncOut
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } syncState_t;

  syncState_t state_q;
  syncState_t state_d;

  // Stage one feeds stage two only, so a metastable value never fans out
  always_comb begin
    state_d        = state_q;
    state_d.stage1 = asyncIn;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.stage2;

endmodule

// file: src/comparator_event_control.sv
// Comparator control: input selection, result sync, edge events, interrupts, AXI4-Lite registers
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module comparator_event_control (
  // Clock and reset
  input  wire logic                                       ref_clk,
  input  wire logic                                       sys_rst,
  // Register bus
  input  wire comparator_event_pkg::axiReq_t              axiReq,
  output comparator_event_pkg::axiRsp_t                   axiRsp,
  // Analog comparator
  input  wire logic                                       rawCompare,
  output logic                                            comparatorOff,
  output logic                                            bandgapSelect,
  output logic [comparator_event_pkg::NEG_PINS-1:0]       negInputSel,
  // Core interrupt handshake
  input  wire logic                                       globalIrqEnable,
  input  wire logic                                       vectorTaken,
  output logic                                            compIrqReq,
  // Timer capture front end
  output logic                                            captureIn,
  // Port pins
  input  wire logic [comparator_event_pkg::PIN_COUNT-1:0] pinRaw,
  output logic [comparator_event_pkg::PIN_COUNT-1:0]      pinBufferOff,
  output logic [comparator_event_pkg::PIN_COUNT-1:0]      pinIn,
  // Summary interrupt
  output logic                                            irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    comparator_event_pkg::ctrl_t                           ctrl;
    logic                                                  flag;
    logic [comparator_event_pkg::NEG_SEL_W-1:0]            negSel;
    logic [comparator_event_pkg::PIN_COUNT-1:0]            bufOff;
    logic [comparator_event_pkg::IRQ_W-1:0]                irqStatus;
    logic [comparator_event_pkg::IRQ_W-1:0]                irqMask;
    logic                                                  resultPrev;
    logic                                                  awHeld;
    logic [comparator_event_pkg::ADDR_W-1:0]               awAddr;
    logic                                                  wHeld;
    logic [comparator_event_pkg::DATA_W-1:0]               wData;
    logic                                                  wLane0;
    comparator_event_pkg::wrState_t                        wrState;
    logic [1:0]                                            bresp;
    logic                                                  rvalid;
    logic [comparator_event_pkg::DATA_W-1:0]               rdata;
    logic [1:0]                                            rresp;
  } state_t;

  localparam state_t STATE_RESET = '0;

  state_t state_q;
  state_t state_d;
  logic   result;
  logic   riseEdge;
  logic   fallEdge;
  logic   compareEvent;
  logic   awFire;
  logic   wFire;
  logic   arFire;
  logic   doWrite;
  logic [comparator_event_pkg::INDEX_W-1:0] wrIndex;
  logic [comparator_event_pkg::INDEX_W-1:0] rdIndex;
  logic [comparator_event_pkg::REG_W-1:0]   wrByte;

  // ----------------------------------------------------------------------
  // Result synchroniser and edge detection
  // ----------------------------------------------------------------------
  comparator_sync comparator_sync_i (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .asyncIn (rawCompare),
    .syncOut (result)
  );

  // Edges come from the synchronised value only, never the raw input
  assign riseEdge = result & ~state_q.resultPrev;
  assign fallEdge = ~result & state_q.resultPrev;

  always_comb begin
    case (state_q.ctrl.eventMode)
      comparator_event_pkg::MODE_TOGGLE: compareEvent = riseEdge | fallEdge;
      comparator_event_pkg::MODE_FALL:   compareEvent = fallEdge;
      comparator_event_pkg::MODE_RISE:   compareEvent = riseEdge;
      default:                           compareEvent = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Bus handshake terms
  // ----------------------------------------------------------------------
  assign axiRsp.awready = ~state_q.awHeld & (state_q.wrState == comparator_event_pkg::WR_COLLECT);
  assign axiRsp.wready  = ~state_q.wHeld & (state_q.wrState == comparator_event_pkg::WR_COLLECT);
  assign axiRsp.arready = ~state_q.rvalid;
  assign axiRsp.bvalid  = state_q.wrState == comparator_event_pkg::WR_RESPOND;
  assign axiRsp.bresp   = state_q.bresp;
  assign axiRsp.rvalid  = state_q.rvalid;
  assign axiRsp.rdata   = state_q.rdata;
  assign axiRsp.rresp   = state_q.rresp;

  assign awFire  = axiReq.awvalid & axiRsp.awready;
  assign wFire   = axiReq.wvalid & axiRsp.wready;
  assign arFire  = axiReq.arvalid & axiRsp.arready;
  // Write lands once both address and data are held, in either order
  assign doWrite = state_q.awHeld & state_q.wHeld;
  assign wrIndex = state_q.awAddr[comparator_event_pkg::ADDR_W-1:2];
  assign rdIndex = axiReq.araddr[comparator_event_pkg::ADDR_W-1:2];
  assign wrByte  = state_q.wData[comparator_event_pkg::REG_W-1:0];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic flagClear;
    logic [comparator_event_pkg::IRQ_W-1:0] irqClear;
    logic mapped;
    logic [comparator_event_pkg::REG_W-1:0] rdByte;
    flagClear = vectorTaken;
    irqClear  = '0;
    mapped    = 1'b1;
    rdByte    = '0;
    state_d   = state_q;
    state_d.resultPrev = result;

    if (awFire) begin
      state_d.awHeld = 1'b1;
      state_d.awAddr = axiReq.awaddr;
    end
    if (wFire) begin
      state_d.wHeld  = 1'b1;
      state_d.wData  = axiReq.wdata;
      state_d.wLane0 = axiReq.wstrb[0];
    end

    if (doWrite) begin
      state_d.awHeld  = 1'b0;
      state_d.wHeld   = 1'b0;
      state_d.wrState = comparator_event_pkg::WR_RESPOND;
      if (wrIndex == comparator_event_pkg::CSR_INDEX) begin
        if (state_q.wLane0) begin
          state_d.ctrl.comparatorOff      = wrByte[comparator_event_pkg::CSR_OFF_BIT];
          state_d.ctrl.bandgapSelect      = wrByte[comparator_event_pkg::CSR_BG_BIT];
          state_d.ctrl.compareIrqEnable   = wrByte[comparator_event_pkg::CSR_IE_BIT];
          state_d.ctrl.captureRouteEnable = wrByte[comparator_event_pkg::CSR_CAP_BIT];
          state_d.ctrl.eventMode          = comparator_event_pkg::eventMode_t'(
            wrByte[comparator_event_pkg::CSR_MODE_HI:comparator_event_pkg::CSR_MODE_LO]);
          flagClear = flagClear | wrByte[comparator_event_pkg::CSR_FLAG_BIT];
        end
      end else if (wrIndex == comparator_event_pkg::INSEL_INDEX) begin
        if (state_q.wLane0) begin
          state_d.negSel = wrByte[comparator_event_pkg::NEG_SEL_W-1:0];
        end
      end else if (wrIndex == comparator_event_pkg::DIDR_INDEX) begin
        if (state_q.wLane0) begin
          state_d.bufOff = wrByte[comparator_event_pkg::PIN_COUNT-1:0];
        end
      end else if (wrIndex == comparator_event_pkg::IRQ_STATUS_INDEX) begin
        if (state_q.wLane0) begin
          irqClear = wrByte[comparator_event_pkg::IRQ_W-1:0];
        end
      end else if (wrIndex == comparator_event_pkg::IRQ_MASK_INDEX) begin
        if (state_q.wLane0) begin
          state_d.irqMask = wrByte[comparator_event_pkg::IRQ_W-1:0];
        end
      end else begin
        mapped = 1'b0;
      end
      state_d.bresp = mapped ? comparator_event_pkg::RESP_OKAY
                             : comparator_event_pkg::RESP_SLVERR;
    end else if (axiRsp.bvalid & axiReq.bready) begin
      state_d.wrState = comparator_event_pkg::WR_COLLECT;
    end

    // A new event in the clearing cycle keeps the bit set
    state_d.flag = (state_q.flag & ~flagClear) | compareEvent;
    state_d.irqStatus = (state_q.irqStatus & ~irqClear)
                      | {riseEdge | fallEdge, compareEvent};

    // Read path: result bit and reserved bits come straight from logic
    if (arFire) begin
      mapped = 1'b1;
      if (rdIndex == comparator_event_pkg::CSR_INDEX) begin
        rdByte = {state_q.ctrl.comparatorOff, state_q.ctrl.bandgapSelect, result,
                  state_q.flag, state_q.ctrl.compareIrqEnable,
                  state_q.ctrl.captureRouteEnable, state_q.ctrl.eventMode};
      end else if (rdIndex == comparator_event_pkg::INSEL_INDEX) begin
        rdByte = {{(comparator_event_pkg::REG_W-comparator_event_pkg::NEG_SEL_W){1'b0}},
                  state_q.negSel};
      end else if (rdIndex == comparator_event_pkg::DIDR_INDEX) begin
        rdByte = {1'b0, state_q.bufOff};
      end else if (rdIndex == comparator_event_pkg::IRQ_STATUS_INDEX) begin
        rdByte = {{(comparator_event_pkg::REG_W-comparator_event_pkg::IRQ_W){1'b0}},
                  state_q.irqStatus};
      end else if (rdIndex == comparator_event_pkg::IRQ_MASK_INDEX) begin
        rdByte = {{(comparator_event_pkg::REG_W-comparator_event_pkg::IRQ_W){1'b0}},
                  state_q.irqMask};
      end else begin
        mapped = 1'b0;
      end
      state_d.rvalid = 1'b1;
      state_d.rdata  = {{(comparator_event_pkg::DATA_W-comparator_event_pkg::REG_W){1'b0}},
                        rdByte};
      state_d.rresp  = mapped ? comparator_event_pkg::RESP_OKAY
                              : comparator_event_pkg::RESP_SLVERR;
    end else if (state_q.rvalid & axiReq.rready) begin
      state_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs to the analog side, timer and core
  // ----------------------------------------------------------------------
  assign comparatorOff = state_q.ctrl.comparatorOff;
  assign bandgapSelect = state_q.ctrl.bandgapSelect;
  // Reserved select codes connect no pin rather than aliasing one
  always_comb begin
    negInputSel = '0;
    if (state_q.negSel < comparator_event_pkg::NEG_SEL_W'(comparator_event_pkg::NEG_PINS)) begin
      negInputSel[state_q.negSel] = 1'b1;
    end
  end
  assign captureIn  = state_q.ctrl.captureRouteEnable & result;
  // Enable-off leaves the flag pending, so the request returns at once after re-enable
  assign compIrqReq = state_q.flag & state_q.ctrl.compareIrqEnable & globalIrqEnable;
  assign irq        = |(state_q.irqStatus & state_q.irqMask);

  genvar pinIdx;
  generate
    for (pinIdx = 0; pinIdx < comparator_event_pkg::PIN_COUNT; pinIdx++) begin : g_pin
      assign pinBufferOff[pinIdx] = state_q.bufOff[pinIdx];
      assign pinIn[pinIdx]        = pinRaw[pinIdx] & ~state_q.bufOff[pinIdx];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  logic csrWrite;
  assign csrWrite = doWrite & state_q.wLane0 & (wrIndex == comparator_event_pkg::CSR_INDEX);

  sequence s_csrWrite;
    csrWrite;
  endsequence

  a_result_sync: assert property (
    ##2 (result == $past(rawCompare, 2)))
    else $error("compare result is not raw input delayed by two clocks");

  a_bandgap_write: assert property (
    s_csrWrite |=> bandgapSelect == $past(wrByte[comparator_event_pkg::CSR_BG_BIT]))
    else $error("bandgap select does not follow control write");

  a_power_write: assert property (
    s_csrWrite |=> comparatorOff == $past(wrByte[comparator_event_pkg::CSR_OFF_BIT]))
    else $error("comparator off does not follow control write");

  sequence s_riseSeen;
    state_q.ctrl.eventMode == comparator_event_pkg::MODE_RISE && !state_q.resultPrev && result;
  endsequence

  a_rise_sets: assert property (
    s_riseSeen |=> state_q.flag)
    else $error("rising edge in rising mode did not set event flag");

  a_fall_ignored: assert property (
    state_q.ctrl.eventMode == comparator_event_pkg::MODE_RISE && !state_q.flag && fallEdge
    |=> !state_q.flag)
    else $error("falling edge set flag in rising mode");

  a_reserved_quiet: assert property (
    state_q.ctrl.eventMode == comparator_event_pkg::MODE_RESERVED && !state_q.flag
    |=> !state_q.flag)
    else $error("flag set while reserved mode selected");

  a_irq_request: assert property (
    compIrqReq == (state_q.flag && state_q.ctrl.compareIrqEnable && globalIrqEnable))
    else $error("irq request not gated by flag and enables");

  a_vector_clear: assert property (
    vectorTaken && !compareEvent |=> !state_q.flag)
    else $error("vector taken did not clear event flag");

  a_set_wins: assert property (
    compareEvent |=> state_q.flag)
    else $error("event lost against a clear");

  a_capture_off: assert property (
    !state_q.ctrl.captureRouteEnable |-> !captureIn)
    else $error("capture input driven while route disabled");

  a_neg_reserved: assert property (
    state_q.negSel >= comparator_event_pkg::NEG_PINS |-> negInputSel == '0)
    else $error("reserved negative select connected a pin");

  a_buffer_zero: assert property (
    (pinIn & pinBufferOff) == '0)
    else $error("disabled pin buffer reads nonzero");

  // Writing zero to the enable must drop a pending request on the next cycle
  a_enable_blocks: assert property (
    csrWrite && !wrByte[comparator_event_pkg::CSR_IE_BIT] |=> !compIrqReq)
    else $error("irq request stayed after enable was cleared");

  a_flag_write_one: assert property (
    csrWrite && wrByte[comparator_event_pkg::CSR_FLAG_BIT] && !compareEvent
    |=> !state_q.flag)
    else $error("writing one did not clear event flag");

  a_flag_write_zero: assert property (
    csrWrite && !wrByte[comparator_event_pkg::CSR_FLAG_BIT] && !vectorTaken && state_q.flag
    |=> state_q.flag)
    else $error("writing zero changed event flag");

  sequence s_fallSeen;
    state_q.ctrl.eventMode == comparator_event_pkg::MODE_FALL && state_q.resultPrev && !result;
  endsequence

  a_fall_sets: assert property (
    s_fallSeen |=> state_q.flag)
    else $error("falling edge in falling mode did not set event flag");

  a_reset_clear: assert property (@(posedge ref_clk)
    $past(sys_rst) |-> state_q.ctrl == '0 && !state_q.flag && state_q.negSel == '0)
    else $error("control or flag not zero after reset");

endmodule

// file: sim/comparator_event_control_tb.sv
// Self-checking bench for the comparator event control block
`timescale 1ns/1ps
module comparator_event_control_tb;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic                                             ref_clk;
  logic                                             sys_rst;
  comparator_event_pkg::axiReq_t                    axiReq;
  comparator_event_pkg::axiRsp_t                    axiRsp;
  logic                                             rawCompare;
  logic                                             globalIrqEnable;
  logic                                             vectorTaken;
  logic [comparator_event_pkg::PIN_COUNT-1:0]       pinRaw;
  logic                                             comparatorOff;
  logic                                             bandgapSelect;
  logic [comparator_event_pkg::NEG_PINS-1:0]        negInputSel;
  logic                                             compIrqReq;
  logic                                             captureIn;
  logic [comparator_event_pkg::PIN_COUNT-1:0]       pinBufferOff;
  logic [comparator_event_pkg::PIN_COUNT-1:0]       pinIn;
  logic                                             irq;
  int                                               err_count;
  int                                               checked;
  logic [31:0]                                      rd;
  logic [1:0]                                       rsp;

  localparam logic [9:0] CSR   = comparator_event_pkg::CSR_INDEX;
  localparam logic [9:0] INSEL = comparator_event_pkg::INSEL_INDEX;
  localparam logic [9:0] DIDR  = comparator_event_pkg::DIDR_INDEX;
  localparam logic [9:0] STAT  = comparator_event_pkg::IRQ_STATUS_INDEX;
  localparam logic [9:0] MASK  = comparator_event_pkg::IRQ_MASK_INDEX;
  localparam logic [7:0] OFF_M = 8'h01 << comparator_event_pkg::CSR_OFF_BIT;
  localparam logic [7:0] BG_M  = 8'h01 << comparator_event_pkg::CSR_BG_BIT;
  localparam logic [7:0] RES_M = 8'h01 << comparator_event_pkg::CSR_RESULT_BIT;
  localparam logic [7:0] FLG_M = 8'h01 << comparator_event_pkg::CSR_FLAG_BIT;
  localparam logic [7:0] IE_M  = 8'h01 << comparator_event_pkg::CSR_IE_BIT;
  localparam logic [7:0] CAP_M = 8'h01 << comparator_event_pkg::CSR_CAP_BIT;

  comparator_event_control comparator_event_control_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .axiReq(axiReq), .axiRsp(axiRsp),
    .rawCompare(rawCompare), .comparatorOff(comparatorOff), .bandgapSelect(bandgapSelect),
    .negInputSel(negInputSel), .globalIrqEnable(globalIrqEnable), .vectorTaken(vectorTaken),
    .compIrqReq(compIrqReq), .captureIn(captureIn), .pinRaw(pinRaw),
    .pinBufferOff(pinBufferOff), .pinIn(pinIn), .irq(irq)
  );

  // ----------------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------------
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic checkResp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang();
    err_count++;
    $display("CHECK FAILED bus answer expected within bound seen none");
    results();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  task automatic axiWrite(input logic [9:0] idx, input logic [7:0] val, output logic [1:0] resp);
    bit done;
    done = 1'b0;
    @(posedge ref_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= {idx, 2'b00};
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= {24'h0, val};
    axiReq.wstrb   <= 4'hf;
    axiReq.bready  <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge ref_clk);
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid) begin
        resp = axiRsp.bresp;
        axiReq.bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) hang();
  endtask

  task automatic axiRead(input logic [9:0] idx, output logic [31:0] data, output logic [1:0] resp);
    bit done;
    done = 1'b0;
    @(posedge ref_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= {idx, 2'b00};
    axiReq.rready  <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge ref_clk);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) begin
        data = axiRsp.rdata;
        resp = axiRsp.rresp;
        axiReq.rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) hang();
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] val);
    axiWrite(idx, val, rsp);
    checkResp("bresp", comparator_event_pkg::RESP_OKAY, rsp);
  endtask

  task automatic rdChk(input logic [9:0] idx, input logic [7:0] m, input logic [7:0] e,
                       input string what);
    axiRead(idx, rd, rsp);
    checkResp("rresp", comparator_event_pkg::RESP_OKAY, rsp);
    checkVal(what, {24'h0, e}, rd & {24'h0, m});
  endtask

  // ----------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    sys_rst = 1'b1;
    axiReq = '0;
    rawCompare = 1'b0;
    globalIrqEnable = 1'b0;
    vectorTaken = 1'b0;
    pinRaw = 7'h55;
    err_count = 0;
    checked = 0;
    tick(20);
    sys_rst <= 1'b0;
    tick(1);
    rdChk(CSR, 8'hff, 8'h00, "control reset");
    rdChk(INSEL, 8'hff, 8'h00, "select reset");
    rdChk(DIDR, 8'hff, 8'h00, "disable reset");
    checkVal("pinIn", 32'h55, pinIn);
    axiWrite(10'h3ff, 8'h5a, rsp);
    checkResp("unmapped bresp", comparator_event_pkg::RESP_SLVERR, rsp);
    axiRead(10'h3ff, rd, rsp);
    checkResp("unmapped rresp", comparator_event_pkg::RESP_SLVERR, rsp);
    checkVal("unmapped rdata", 32'h0, rd);
    // Upper select bits are unimplemented and must stay zero
    wr(INSEL, 8'hff);
    rdChk(INSEL, 8'hff, 8'h07, "select bits");
    for (int c = 0; c < 8; c++) begin
      wr(INSEL, 8'(c));
      checkVal("negInputSel", (c < 6) ? (32'h1 << c) : 32'h0, negInputSel);
    end
    pinRaw <= 7'h7f;
    wr(DIDR, 8'hff);
    rdChk(DIDR, 8'hff, 8'h7f, "disable bits");
    checkVal("pinBufferOff", 32'h7f, pinBufferOff);
    checkVal("pinIn", 32'h0, pinIn);
    wr(DIDR, 8'h03);
    checkVal("pinIn", 32'h7c, pinIn);
    wr(CSR, OFF_M | BG_M);
    checkVal("comparatorOff", 32'h1, comparatorOff);
    checkVal("bandgapSelect", 32'h1, bandgapSelect);
    wr(CSR, 8'h00);
    checkVal("comparatorOff", 32'h0, comparatorOff);
    checkVal("bandgapSelect", 32'h0, bandgapSelect);
    // Every event mode sees one rising and one falling edge
    for (int m = 0; m < 4; m++) begin
      wr(CSR, FLG_M | 8'(m));
      rawCompare <= 1'b1;
      tick(5);
      rdChk(CSR, FLG_M | RES_M, RES_M | ((m == 0 || m == 3) ? FLG_M : 8'h00), "rise");
      wr(CSR, FLG_M | 8'(m));
      rawCompare <= 1'b0;
      tick(5);
      rdChk(CSR, FLG_M | RES_M, (m == 0 || m == 2) ? FLG_M : 8'h00, "fall");
    end
    wr(CSR, FLG_M | IE_M | CAP_M | 8'h03);
    globalIrqEnable <= 1'b1;
    rawCompare <= 1'b1;
    tick(5);
    checkVal("captureIn", 32'h1, captureIn);
    checkVal("compIrqReq", 32'h1, compIrqReq);
    globalIrqEnable <= 1'b0;
    tick(1);
    checkVal("compIrqReq", 32'h0, compIrqReq);
    globalIrqEnable <= 1'b1;
    wr(CSR, CAP_M | 8'h03);
    checkVal("compIrqReq", 32'h0, compIrqReq);
    rdChk(CSR, FLG_M, FLG_M, "flag after zero write");
    vectorTaken <= 1'b1;
    tick(1);
    vectorTaken <= 1'b0;
    tick(1);
    rdChk(CSR, FLG_M, 8'h00, "flag after vector");
    wr(CSR, 8'h03);
    checkVal("captureIn", 32'h0, captureIn);
    // Summary interrupt: masked, unmasked, then cleared
    wr(MASK, 8'h00);
    wr(STAT, 8'h03);
    rawCompare <= 1'b0;
    tick(5);
    checkVal("irq masked", 32'h0, irq);
    rdChk(STAT, 8'h03, 8'h02, "toggle status");
    wr(MASK, 8'h02);
    checkVal("irq", 32'h1, irq);
    wr(STAT, 8'h02);
    checkVal("irq cleared", 32'h0, irq);
    rdChk(MASK, 8'hff, 8'h02, "mask");
    results();
  end
endmodule
